// File: common/comparator_output_control_defines.vh
// What this block does
// RULE_01: raw result is one when positive input exceeds negative input, else zero
// RULE_02: output equals raw result xor output_invert
// RULE_03: during start-up after enable, output holds output_initial_level
// RULE_04: hysteresis_select picks none or one of three hysteresis levels
// RULE_05: positive selector picks pins only; negative adds the reference divider
// RULE_06: reference voltage is internal_reference_code over 256 times reference
// RULE_07: output is given as a level event, asynchronous, following output level; the code registers o_compare_event on i_clock alongside the pin
// RULE_08: block consumes no events; it only generates them
// RULE_09: configured edge on output sets compare_irq_flag
// RULE_10: edge_sense_select chooses rising, falling or both edges
// RULE_11: interrupt only when compare_irq_enable and compare_irq_flag are set
// RULE_12: interrupt stays asserted until software clears the flag
// RULE_13: idle sleep leaves everything running
// RULE_14: standby disables comparator unless keep_running_in_standby is one
// RULE_15: power-down disables comparator and pad drive
// RULE_16: power profile field selects current versus response time
// RULE_17: software sets analog pins, selectors, optional output, then enable
// RULE_18: pin driven only while pin_output_enable is one
// RULE_19: software sets the output pin as output to avoid floating
// RULE_20: compare_output_state mirrors output through synchroniser, three cycles late
// RULE_21: edge encoding 0 both, 2 falling, 3 rising, 1 reserved
// RULE_22: writing one to the flag bit clears it; zero leaves it
`ifndef COMPARATOR_OUTPUT_CONTROL_DEFINES_VH
`define COMPARATOR_OUTPUT_CONTROL_DEFINES_VH

`define ADDR_CONTROL_A      3'h0
`define ADDR_INPUT_CONTROL  3'h2
`define ADDR_REFERENCE      3'h5
`define ADDR_IRQ_CONTROL    3'h6
`define ADDR_STATUS         3'h7

`define CTRLA_ENABLE        0
`define CTRLA_HYST_LO       1
`define CTRLA_POWER_LO      3
`define CTRLA_PIN_OUT       6
`define CTRLA_STANDBY_RUN   7
`define CTRLA_MASK          8'hdf

`define MUX_NEG_LO          0
`define MUX_POS_LO          3
`define MUX_INIT_LEVEL      6
`define MUX_INVERT          7

`define IRQ_ENABLE_BIT      0
`define IRQ_EDGE_LO         4
`define IRQ_MASK            8'h31

`define STATUS_FLAG         0
`define STATUS_STATE        4

`define RESET_CONTROL_A     8'h00
`define RESET_INPUT_CONTROL 8'h00
`define RESET_REFERENCE     8'hff
`define RESET_IRQ_CONTROL   8'h00

`define EDGE_BOTH           2'h0
`define EDGE_FALLING        2'h2
`define EDGE_RISING         2'h3

`define SLEEP_ACTIVE        2'h0
`define SLEEP_IDLE          2'h1
`define SLEEP_STANDBY       2'h2
`define SLEEP_POWER_DOWN    2'h3

`define STARTUP_NS          1000
`define CLOCK_PERIOD_NS     4
`define STARTUP_CYCLES      ((`STARTUP_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// File: dv/analog_front_model.sv
`timescale 1ns/1ps
// far side: analog pins and the reference divider feeding the comparator core
module analog_front_model #(
    parameter VREF_MV = 1024
) (
    input  wire        i_clock,
    input  wire        i_enable,
    input  wire [2:0]  i_pos_sel,
    input  wire [2:0]  i_neg_sel,
    input  wire [7:0]  i_ref_code,
    input  wire [63:0] i_pin_mv,
    output wire        o_raw
);
    reg         junk_q = 1'b0;
    wire [31:0] ref_mv = i_ref_code * VREF_MV / 256;
    // positive side offers pins only, negative adds the divider
    wire [31:0] pos_mv = (i_pos_sel == 3'h4) ? i_pin_mv[31:16] : i_pin_mv[15:0];
    wire [31:0] neg_mv = (i_neg_sel == 3'h4) ? ref_mv :
                         (i_neg_sel == 3'h3) ? i_pin_mv[63:48] : i_pin_mv[47:32];
    // a core that is off gives noise, never its last answer
    always @(posedge i_clock) junk_q <= ~junk_q;
    // hysteresis and profile only shift threshold and delay; inputs kept far apart
    assign o_raw = i_enable ? (pos_mv > neg_mv) : junk_q;
endmodule

// File: dv/comparator_output_control_checker.sv
`timescale 1ns/1ps
module comparator_output_control_checker #(
    parameter STARTUP_COUNT = 4
) (
    input wire       i_clock,
    input wire       i_rst_n,
    input wire       i_wb_we,
    input wire       i_wb_cyc,
    input wire       i_wb_stb,
    input wire [7:0] o_wb_dat,
    input wire       o_wb_ack,
    input wire [1:0] i_sleep_mode,
    input wire       o_analog_enable,
    input wire [2:0] o_positive_input_select,
    input wire       o_compare_pin,
    input wire       o_compare_pin_oe,
    input wire       o_compare_event,
    input wire       o_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire wr = i_wb_cyc && i_wb_stb && i_wb_we;
    ack_one_cycle_a:
        assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
    ack_answer_a:
        assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
    read_idle_zero_a:
        assert property (!o_wb_ack |-> o_wb_dat == 8'h00) else $error("data without ack");
    event_level_a:
        assert property (o_compare_event == o_compare_pin) else $error("event differs");
    irq_held_a:
        assert property (o_irq && !wr |=> o_irq) else $error("irq dropped alone");
    power_down_off_a:
        assert property (i_sleep_mode == 2'h3 [*2] |-> !o_compare_pin_oe && !o_analog_enable)
            else $error("active in power-down");
    startup_hold_a:
        assert property ($rose(o_analog_enable) |-> $stable(o_compare_pin) [*2])
            else $error("pin moved in start-up");
    select_steady_a:
        assert property (!wr |=> $stable(o_positive_input_select)) else $error("select moved");
endmodule

bind comparator_output_control comparator_output_control_checker #(
    .STARTUP_COUNT(STARTUP_COUNT)
) i_checker (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wb_we(i_wb_we), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .i_sleep_mode(i_sleep_mode), .o_analog_enable(o_analog_enable),
    .o_positive_input_select(o_positive_input_select), .o_compare_pin(o_compare_pin),
    .o_compare_pin_oe(o_compare_pin_oe), .o_compare_event(o_compare_event), .o_irq(o_irq));

// File: dv/tb_top.sv
`timescale 1ns/1ps
`include "comparator_output_control_defines.vh"
module tb_top;
    // {irq enable, edge code, sets on rise, sets on fall}
    localparam [24:0] EDGES = {5'b10011, 5'b11001, 5'b11110, 5'b10100, 5'b00011};
    reg         clock = 1'b0;
    reg         rst_n = 1'b0;
    reg  [2:0]  adr = 3'h0;
    reg  [7:0]  wdat = 8'h00;
    reg         we = 1'b0;
    reg         sel = 1'b1;
    reg         cyc = 1'b0;
    reg         stb = 1'b0;
    reg  [1:0]  sleep = 2'h0;
    reg  [63:0] mv = 64'd100;
    reg  [7:0]  r;
    wire [7:0]  rdat, refc;
    wire [1:0]  hyst, pwr;
    wire [2:0]  psel, nsel;
    wire        ack, raw, aen, pin, oe, evt, irq;
    integer     n_errors = 0;
    integer     check_count = 0;
    always #2 clock = ~clock;
    comparator_output_control #(.STARTUP_COUNT(4)) i_dut (
        .i_clock(clock), .i_rst_n(rst_n), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_we(we),
        .i_wb_sel(sel), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_compare_raw(raw), .i_sleep_mode(sleep), .o_analog_enable(aen),
        .o_hysteresis_select(hyst), .o_power_profile(pwr), .o_positive_input_select(psel),
        .o_negative_input_select(nsel), .o_internal_reference_code(refc),
        .o_compare_pin(pin), .o_compare_pin_oe(oe), .o_compare_event(evt), .o_irq(irq));
    analog_front_model i_front (.i_clock(clock), .i_enable(aen), .i_pos_sel(psel),
        .i_neg_sel(nsel), .i_ref_code(refc), .i_pin_mv(mv), .o_raw(raw));
    task print_verdict;
        begin
            if (n_errors == 0 && check_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task idle(input integer c);
        repeat (c) @(posedge clock);
    endtask
    task wb(input [2:0] a, input w, input [7:0] d);
        integer k;
        begin
            cyc <= 1'b1;
            stb <= 1'b1;
            adr <= a;
            we <= w;
            wdat <= d;
            k = 0;
            @(posedge clock);
            while (ack !== 1'b1 && k < 20) begin
                @(posedge clock);
                k = k + 1;
            end
            if (ack !== 1'b1) begin
                n_errors = n_errors + 1;
                print_verdict;
            end
            r = rdat;
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge clock);
        end
    endtask
    task t_regs;
        begin
            wb(3'h1, 1'b1, 8'h5a);
            wb(3'h1, 1'b0, 8'h00);
            check(r, 8'h00); // unmapped place stays empty
            sel <= 1'b0;
            wb(`ADDR_REFERENCE, 1'b1, 8'h40);
            sel <= 1'b1;
            wb(`ADDR_REFERENCE, 1'b0, 8'h00);
            check(r, `RESET_REFERENCE);
        end
    endtask
    task t_output;
        begin
            wb(`ADDR_REFERENCE, 1'b1, 8'h40);
            wb(`ADDR_INPUT_CONTROL, 1'b1, 8'h5c);
            check(psel, 3'h3);
            check(nsel, 3'h4);
            check(refc, 8'h40);
            wb(`ADDR_CONTROL_A, 1'b1, 8'h57);
            check(pin, 1'b1);
            check({hyst, pwr, oe}, 5'h1d);
            idle(8);
            check(pin, 1'b0);
            wb(`ADDR_INPUT_CONTROL, 1'b1, 8'hdc);
            idle(6);
            check(pin, 1'b1);
            wb(`ADDR_STATUS, 1'b0, 8'h00);
            check(r & 8'h10, 8'h10);
            wb(`ADDR_CONTROL_A, 1'b1, 8'h01);
            check(oe, 1'b0);
            wb(`ADDR_INPUT_CONTROL, 1'b1, 8'h5c);
        end
    endtask
    task t_edges;
        integer i;
        reg [4:0] e;
        for (i = 4; i >= 0; i = i - 1) begin
            e = EDGES[i*5 +: 5];
            wb(`ADDR_IRQ_CONTROL, 1'b1, {2'b00, e[3:2], 3'b000, e[4]});
            wb(`ADDR_STATUS, 1'b1, 8'h01);
            check(irq, 1'b0);
            mv <= 64'd500;
            idle(6);
            wb(`ADDR_STATUS, 1'b1, 8'h00);
            wb(`ADDR_STATUS, 1'b0, 8'h00);
            check(r[0], e[1]);
            check(irq, e[4] & e[1]);
            wb(`ADDR_STATUS, 1'b1, 8'h01);
            mv <= 64'd100;
            idle(6);
            wb(`ADDR_STATUS, 1'b0, 8'h00);
            check(r[0], e[0]);
        end
    endtask
    task t_sleep;
        begin
            sleep <= `SLEEP_IDLE;
            mv <= 64'd500;
            idle(6);
            check(pin, 1'b1);
            sleep <= `SLEEP_STANDBY;
            mv <= 64'd100;
            idle(3);
            check(aen, 1'b0);
            check(pin, 1'b1);
            wb(`ADDR_CONTROL_A, 1'b1, 8'hc1);
            check({aen, oe}, 2'h3);
            sleep <= `SLEEP_POWER_DOWN;
            idle(3);
            check({aen, oe}, 2'h0);
            sleep <= `SLEEP_ACTIVE;
            idle(3);
            check(aen, 1'b1);
        end
    endtask
    initial begin
        idle(10);
        rst_n <= 1'b1;
        t_regs;
        t_output;
        t_edges;
        t_sleep;
        print_verdict;
    end
endmodule

// File: hdl/comparator_output_control.v
`timescale 1ns/1ps
`include "comparator_output_control_defines.vh"

module comparator_output_control #(
    parameter STARTUP_COUNT = `STARTUP_CYCLES
) (
    input  wire        i_clock,
    input  wire        i_rst_n,
    input  wire [2:0]  i_wb_adr,
    input  wire [7:0]  i_wb_dat,
    input  wire        i_wb_we,
    input  wire        i_wb_sel,
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    output reg  [7:0]  o_wb_dat,
    output reg         o_wb_ack,
    input  wire        i_compare_raw,
    input  wire [1:0]  i_sleep_mode,
    output reg         o_analog_enable,
    output reg  [1:0]  o_hysteresis_select,
    output reg  [1:0]  o_power_profile,
    output reg  [2:0]  o_positive_input_select,
    output reg  [2:0]  o_negative_input_select,
    output reg  [7:0]  o_internal_reference_code,
    output reg         o_compare_pin,
    output reg         o_compare_pin_oe,
    output reg         o_compare_event,
    output reg         o_irq
);
    localparam ST_OFF     = 3'b001;
    localparam ST_STARTUP = 3'b010;
    localparam ST_RUN     = 3'b100;

    reg [7:0]  control_a_q;
    reg [7:0]  input_control_q;
    reg [7:0]  reference_q;
    reg [7:0]  irq_control_q;
    reg        irq_flag_q;
    reg        out_q;
    reg        out_prev_q;
    reg [2:0]  state_q;
    reg [2:0]  state_d;
    reg [31:0] startup_cnt_q;
    reg [7:0]  rd_d;
    reg        edge_hit;
    reg        out_d;
    wire       state_sync;

    wire wr_req = i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel & ~o_wb_ack;
    wire rd_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire [1:0] edge_sel = irq_control_q[`IRQ_EDGE_LO +: 2];

    // enable is gated by sleep mode
    wire run_allowed = (i_sleep_mode == `SLEEP_ACTIVE)
                     | (i_sleep_mode == `SLEEP_IDLE) // see RULE_13
                     | ((i_sleep_mode == `SLEEP_STANDBY)
                        & control_a_q[`CTRLA_STANDBY_RUN]); // see RULE_14
    wire comp_on = control_a_q[`CTRLA_ENABLE] & run_allowed; // see RULE_15

    function [7:0] reg_read;
        input [2:0] adr;
        begin
            case (adr)
                `ADDR_CONTROL_A:     reg_read = control_a_q;
                `ADDR_INPUT_CONTROL: reg_read = input_control_q;
                `ADDR_REFERENCE:     reg_read = reference_q;
                `ADDR_IRQ_CONTROL:   reg_read = irq_control_q;
                // state bit is the synchronised copy; see RULE_20
                `ADDR_STATUS:        reg_read = {3'h0, state_sync, 3'h0, irq_flag_q};
                default:             reg_read = 8'h00;
            endcase
        end
    endfunction

    always @* begin
        rd_d = reg_read(i_wb_adr);
    end

    // wishbone slave: ack one cycle after request, unmapped reads zero, writes ignored
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wb_ack        <= 1'b0;
            o_wb_dat        <= 8'h00;
            control_a_q     <= `RESET_CONTROL_A;
            input_control_q <= `RESET_INPUT_CONTROL;
            reference_q     <= `RESET_REFERENCE;
            irq_control_q   <= `RESET_IRQ_CONTROL;
        end else begin
            o_wb_ack <= rd_req;
            o_wb_dat <= rd_req ? rd_d : 8'h00;
            if (wr_req) begin
                case (i_wb_adr)
                    `ADDR_CONTROL_A:     control_a_q     <= i_wb_dat & `CTRLA_MASK;
                    `ADDR_INPUT_CONTROL: input_control_q <= i_wb_dat;
                    `ADDR_REFERENCE:     reference_q     <= i_wb_dat;
                    `ADDR_IRQ_CONTROL:   irq_control_q   <= i_wb_dat & `IRQ_MASK;
                    default:             control_a_q     <= control_a_q;
                endcase
            end
        end
    end

    // start-up sequencing; restarts whenever the comparator is switched back on
    always @* begin
        case (state_q)
            ST_OFF:     state_d = comp_on ? ST_STARTUP : ST_OFF;
            ST_STARTUP: state_d = !comp_on ? ST_OFF
                                : (startup_cnt_q >= STARTUP_COUNT - 1) ? ST_RUN : ST_STARTUP;
            ST_RUN:     state_d = comp_on ? ST_RUN : ST_OFF;
            default:    state_d = ST_OFF;
        endcase
    end

    always @* begin
        if (state_q == ST_RUN) begin
            out_d = i_compare_raw ^ input_control_q[`MUX_INVERT]; // see RULE_01 see RULE_02
        end else begin
            out_d = input_control_q[`MUX_INIT_LEVEL]; // see RULE_03
        end
    end

    always @* begin
        case (edge_sel) // see RULE_10 see RULE_21
            `EDGE_BOTH:    edge_hit = out_q ^ out_prev_q;
            `EDGE_FALLING: edge_hit = ~out_q & out_prev_q;
            `EDGE_RISING:  edge_hit = out_q & ~out_prev_q;
            default:       edge_hit = 1'b0;
        endcase
    end

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q       <= ST_OFF;
            startup_cnt_q <= 32'h0;
            out_q         <= 1'b0;
            out_prev_q    <= 1'b0;
            irq_flag_q    <= 1'b0;
        end else begin
            state_q       <= state_d;
            startup_cnt_q <= (state_q == ST_STARTUP) ? startup_cnt_q + 32'h1 : 32'h0;
            out_q         <= out_d;
            out_prev_q    <= out_q;
            // set wins over a clearing write in the same cycle
            if (edge_hit & (state_q == ST_RUN)) begin
                irq_flag_q <= 1'b1; // see RULE_09
            end else if (wr_req && i_wb_adr == `ADDR_STATUS && i_wb_dat[`STATUS_FLAG]) begin
                irq_flag_q <= 1'b0; // see RULE_22
            end
        end
    end

    state_sync3 u_state_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_level (out_q),
        .o_level (state_sync)
    );

    // outputs registered; the event is a level copy, so it carries no edge timing of its own
    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_analog_enable           <= 1'b0;
            o_hysteresis_select       <= 2'h0;
            o_power_profile           <= 2'h0;
            o_positive_input_select   <= 3'h0;
            o_negative_input_select   <= 3'h0;
            o_internal_reference_code <= 8'h00;
            o_compare_pin             <= 1'b0;
            o_compare_pin_oe          <= 1'b0;
            o_compare_event           <= 1'b0;
            o_irq                     <= 1'b0;
        end else begin
            o_analog_enable           <= comp_on; // see RULE_14 see RULE_15
            o_hysteresis_select       <= control_a_q[`CTRLA_HYST_LO +: 2]; // see RULE_04
            o_power_profile           <= control_a_q[`CTRLA_POWER_LO +: 2]; // see RULE_16
            o_positive_input_select   <= input_control_q[`MUX_POS_LO +: 3]; // see RULE_05
            o_negative_input_select   <= input_control_q[`MUX_NEG_LO +: 3]; // see RULE_05
            o_internal_reference_code <= reference_q; // see RULE_06
            o_compare_pin             <= out_d;
            o_compare_pin_oe          <= control_a_q[`CTRLA_PIN_OUT]
                                       & (i_sleep_mode != `SLEEP_POWER_DOWN); // see RULE_18
            o_compare_event           <= out_d; // see RULE_07 see RULE_08
            o_irq                     <= irq_control_q[`IRQ_ENABLE_BIT]
                                       & irq_flag_q; // see RULE_11 see RULE_12
        end
    end
endmodule

// File: hdl/state_sync3.v
`timescale 1ns/1ps
// three-stage synchroniser; only the second stage reads the first
module state_sync3 (
    input  wire i_clock,
    input  wire i_rst_n,
    input  wire i_level,
    output wire o_level
);
    reg [2:0] stage_q;

    always @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stage_q <= 3'h0;
        end else begin
            stage_q <= {stage_q[1:0], i_level}; // see RULE_20
        end
    end

    assign o_level = stage_q[2];
endmodule
